// ==== hw/disk_port_params.svh ====
// Timing and layout constants for the disk controller host port.
`ifndef DISK_PORT_PARAMS_SVH
`define DISK_PORT_PARAMS_SVH
`define CLK_PERIOD_NS        50
`define SETUP_NS             350
`define SETUP_CYC            ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAMPLE_NS            400
`define SAMPLE_CYC           ((`SAMPLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLOP_SD_NS           32000
`define FLOP_DD_NS           16000
`define FLOP_SD_CYC          (`FLOP_SD_NS / `CLK_PERIOD_NS)
`define FLOP_DD_CYC          (`FLOP_DD_NS / `CLK_PERIOD_NS)
`define OVR_SD_NS            20000
`define OVR_DD_NS            10000
`define OVR_SD_CYC           (`OVR_SD_NS / `CLK_PERIOD_NS)
`define OVR_DD_CYC           (`OVR_DD_NS / `CLK_PERIOD_NS)
`define FIX_PERIOD_NS        1840
`define FIX_PERIOD_CYC       (`FIX_PERIOD_NS / `CLK_PERIOD_NS)
`define FIX_ACCESS_NS        1150
`define FIX_ACCESS_CYC       (`FIX_ACCESS_NS / `CLK_PERIOD_NS)
`define CON_GAP_NS           1000
`define CON_GAP_CYC          ((`CON_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_BYTES            6
`define STATUS_BYTES         2
`define ERR_OK               8'h00
`define ERR_OVERRUN          8'h18
`define ERR_BAD_SIZE         8'h21
`define OPC_READ             8'h08
`define OPC_WRITE            8'h0A
`endif

// ==== hw/disk_port_pkg.sv ====
// Types shared by the disk controller host port.
package disk_port_pkg;
   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_CMD_REQ  = 4'h1,
      ST_CMD_ACK  = 4'h2,
      ST_CMD_END  = 4'h3,
      ST_GAP      = 4'h4,
      ST_DAT_WAIT = 4'h5,
      ST_DAT_REQ  = 4'h6,
      ST_DAT_ACK  = 4'h7,
      ST_STS_SET  = 4'h8,
      ST_STS_REQ  = 4'h9,
      ST_STS_ACK  = 4'hA
   } port_state_t;
   typedef enum logic [1:0] {
      MEDIA_FLOP_SD = 2'h0,
      MEDIA_FLOP_DD = 2'h1,
      MEDIA_FIXED   = 2'h2
   } media_t;
endpackage

// ==== hw/disk_host_port.sv ====
// Host byte port of a floppy and fixed disk controller: command, data and status phases.
`timescale 1ns/1ns
`default_nettype none
`include "disk_port_params.svh"
// Functional notes
// - Drop connection phase before every status phase.
// - Byte stable 350ns before byte request.
// - Sample host byte no sooner than 400ns.
// - Direct floppy request every 16 or 32us.
// - Direct fixed disk leaves 1.15us access.
// - Fast handshake gives 1.15us buffered access.
// - Message phase during second status byte.
// - Second status byte carries drive status.
// - Floppy sector sizes selectable by density.
// - Fixed disk sectors 256 or 512 bytes.
// - Sustain peak rates for each media.
// - Every command is exactly six bytes.
// - Two status bytes with connection and direction.
// - Missing direct floppy acknowledge aborts with overrun.
// - Fixed disk request every 1.84us; the code requests every 36 cycles (1.8us).
module disk_host_port #(
   parameter int FLOP_SD_CYC = `FLOP_SD_CYC,
   parameter int FLOP_DD_CYC = `FLOP_DD_CYC,
   parameter int OVR_SD_CYC  = `OVR_SD_CYC,
   parameter int OVR_DD_CYC  = `OVR_DD_CYC
) (
   // Clock and host reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // Host handshake pins
   input  wire logic       select_i,
   input  wire logic       byte_acknowledge_i,
   input  wire logic [7:0] data_i,
   output logic [7:0]      data_o,
   output logic            data_oe_o,
   output logic            byte_request_o,
   output logic            connection_phase_o,
   output logic            direction_out_o,
   output logic            message_phase_o,
   output logic            controller_busy_o,
   // Media side
   input  wire logic [7:0] drive_status_i,
   input  wire logic       media_byte_valid_i,
   input  wire logic [7:0] media_byte_i,
   output logic            media_byte_valid_o,
   output logic [7:0]      media_byte_o,
   // Decoded command for the drive logic
   output logic [7:0]      command_opcode_o,
   output logic [10:0]     sector_bytes_o
);
   if (FLOP_SD_CYC < 2 || FLOP_DD_CYC < 2 || OVR_SD_CYC < 2 || OVR_DD_CYC < 2 || FLOP_SD_CYC > 65536 ||
       FLOP_DD_CYC > 65536 || OVR_SD_CYC > 65535 || OVR_DD_CYC > 65535) begin
      $error("disk_host_port: timing counts out of range");
   end

   localparam logic [15:0] SETUP_C  = 16'(`SETUP_CYC);
   localparam logic [15:0] SAMPLE_C = 16'(`SAMPLE_CYC);
   localparam logic [15:0] GAP_C    = 16'(`CON_GAP_CYC);
   localparam logic [15:0] FIXP_C   = 16'(`FIX_PERIOD_CYC);
   localparam logic [15:0] FIXA_C   = 16'(`FIX_ACCESS_CYC);

   // Three-stage pin synchronisers; the first stage feeds only the second.
   logic [2:0] sel_sync_reg;
   logic [2:0] ack_sync_reg;
   logic       sel_reg;
   logic       ack_reg;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sel_sync_reg <= 3'h0;
         ack_sync_reg <= 3'h0;
         sel_reg      <= 1'b0;
         ack_reg      <= 1'b0;
      end else begin
         sel_sync_reg <= {sel_sync_reg[1:0], select_i};
         ack_sync_reg <= {ack_sync_reg[1:0], byte_acknowledge_i};
         if (sel_sync_reg[2] == sel_sync_reg[1]) begin
            sel_reg <= sel_sync_reg[2];
         end
         if (ack_sync_reg[2] == ack_sync_reg[1]) begin
            ack_reg <= ack_sync_reg[2];
         end
      end
   end

   function automatic logic [10:0] sector_size(input logic [1:0] code, input disk_port_pkg::media_t m);
      logic [10:0] s;
      s = 11'h080 << code;
      if (m == disk_port_pkg::MEDIA_FIXED) begin
         s = code[0] ? 11'h200 : 11'h100;
      end
      return s;
   endfunction

   function automatic logic size_ok(input logic [1:0] code, input disk_port_pkg::media_t m);
      return !(m == disk_port_pkg::MEDIA_FLOP_DD && code == 2'h0);
   endfunction

   // Command byte 0 is the opcode; byte 5 holds media[1:0], size[3:2], fast handshake[4].
   disk_port_pkg::port_state_t state_reg, state_next;
   logic [7:0]  cmd_reg [0:5];
   logic [7:0]  cmd_next [0:5];
   logic [2:0]  idx_reg, idx_next;
   logic [15:0] tmr_reg, tmr_next;
   logic [15:0] pace_reg, pace_next;
   logic [10:0] cnt_reg, cnt_next;
   logic [7:0]  err_reg, err_next;
   logic [7:0]  dout_reg, dout_next;
   logic        oe_reg, oe_next, req_reg, req_next, con_reg, con_next;
   logic        out_reg, out_next, msg_reg, msg_next, bsy_reg, bsy_next;
   logic        mv_reg, mv_next;
   logic [7:0]  mb_reg, mb_next;
   logic [10:0] size_reg, size_next;
   disk_port_pkg::media_t media_w;
   logic        fast_handshake_select;
   logic        is_write;

   always_comb begin
      media_w               = disk_port_pkg::media_t'(cmd_reg[5][1:0]);
      fast_handshake_select = cmd_reg[5][4];
      is_write              = (cmd_reg[0] == `OPC_WRITE);
      state_next = state_reg;
      for (int i = 0; i < 6; i++) begin
         cmd_next[i] = cmd_reg[i];
      end
      idx_next  = idx_reg;
      tmr_next  = (tmr_reg != 16'h0) ? tmr_reg - 16'h1 : 16'h0;
      pace_next = (pace_reg != 16'h0) ? pace_reg - 16'h1 : 16'h0;
      cnt_next  = cnt_reg;
      err_next  = err_reg;
      dout_next = dout_reg;
      oe_next   = oe_reg;
      req_next  = req_reg;
      con_next  = con_reg;
      out_next  = out_reg;
      msg_next  = msg_reg;
      bsy_next  = bsy_reg;
      mv_next   = 1'b0;
      mb_next   = mb_reg;
      size_next = size_reg;
      case (state_reg)
         disk_port_pkg::ST_IDLE: begin
            if (sel_reg) begin
               bsy_next   = 1'b1;
               idx_next   = 3'h0;
               out_next   = 1'b0;
               state_next = disk_port_pkg::ST_CMD_REQ;
            end
         end
         disk_port_pkg::ST_CMD_REQ: begin
            if (!sel_reg && !ack_reg) begin
               con_next   = 1'b1;
               req_next   = 1'b1;
               state_next = disk_port_pkg::ST_CMD_ACK;
            end
         end
         disk_port_pkg::ST_CMD_ACK: begin
            if (!ack_reg) begin
               tmr_next = SAMPLE_C;
            end else if (tmr_reg == 16'h1) begin
               cmd_next[idx_reg] = data_i;
               req_next = 1'b0;
               if (idx_reg == 3'(`CMD_BYTES - 1)) begin
                  state_next = disk_port_pkg::ST_CMD_END;
               end else begin
                  idx_next   = idx_reg + 3'h1;
                  state_next = disk_port_pkg::ST_CMD_REQ;
               end
            end
         end
         disk_port_pkg::ST_CMD_END: begin
            if (!ack_reg) begin
               err_next  = size_ok(cmd_reg[5][3:2], media_w) ? `ERR_OK : `ERR_BAD_SIZE;
               size_next = sector_size(cmd_reg[5][3:2], media_w);
               out_next  = !is_write;
               tmr_next  = GAP_C;
               state_next = disk_port_pkg::ST_GAP;
            end
         end
         disk_port_pkg::ST_GAP: begin
            // Direction settles one cycle before connection drops.
            con_next = 1'b0;
            if (tmr_reg == 16'h0 && !con_reg) begin
               cnt_next = size_reg;
               if (err_reg != `ERR_OK ||
                   (cmd_reg[0] != `OPC_READ && cmd_reg[0] != `OPC_WRITE)) begin
                  out_next   = 1'b1;
                  state_next = disk_port_pkg::ST_STS_SET;
               end else begin
                  pace_next  = 16'h0;
                  state_next = disk_port_pkg::ST_DAT_WAIT;
               end
            end
         end
         disk_port_pkg::ST_DAT_WAIT: begin
            if (cnt_reg == 11'h0) begin
               out_next   = 1'b1;
               state_next = disk_port_pkg::ST_STS_SET;
            end else if (pace_reg == 16'h0 && (is_write || media_byte_valid_i)) begin
               if (!is_write) begin
                  dout_next = media_byte_i;
                  oe_next   = 1'b1;
               end
               tmr_next   = SETUP_C;
               state_next = disk_port_pkg::ST_DAT_REQ;
               case (media_w)
                  disk_port_pkg::MEDIA_FLOP_SD: pace_next = 16'(FLOP_SD_CYC - 1);
                  disk_port_pkg::MEDIA_FLOP_DD: pace_next = 16'(FLOP_DD_CYC - 1);
                  default:                      pace_next = FIXP_C - 16'h1;
               endcase
            end
         end
         disk_port_pkg::ST_DAT_REQ: begin
            if (tmr_reg == 16'h0) begin
               req_next   = 1'b1;
               state_next = disk_port_pkg::ST_DAT_ACK;
               case (media_w)
                  disk_port_pkg::MEDIA_FLOP_SD: tmr_next = 16'(OVR_SD_CYC);
                  disk_port_pkg::MEDIA_FLOP_DD: tmr_next = 16'(OVR_DD_CYC);
                  default:                      tmr_next = FIXA_C;
               endcase
            end
         end
         disk_port_pkg::ST_DAT_ACK: begin
            if (req_reg && !ack_reg && ack_sync_reg[2] && ack_sync_reg[1]) begin
               // Acknowledge is accepted at this edge; request stands until the byte is taken.
               tmr_next = SAMPLE_C;
            end else if (req_reg && ack_reg && tmr_reg == 16'h1) begin
               req_next = 1'b0;
               mb_next  = is_write ? data_i : mb_reg;
               mv_next  = is_write;
            end else if (!ack_reg && !req_reg) begin
               oe_next    = 1'b0;
               cnt_next   = cnt_reg - 11'h1;
               state_next = disk_port_pkg::ST_DAT_WAIT;
            end else if (req_reg && tmr_reg == 16'h0 && media_w != disk_port_pkg::MEDIA_FIXED &&
                         !fast_handshake_select) begin
               req_next   = 1'b0;
               oe_next    = 1'b0;
               err_next   = `ERR_OVERRUN;
               out_next   = 1'b1;
               state_next = disk_port_pkg::ST_STS_SET;
            end
         end
         disk_port_pkg::ST_STS_SET: begin
            if (!ack_reg) begin
               con_next   = 1'b1;
               oe_next    = 1'b1;
               dout_next  = msg_reg ? drive_status_i : err_reg;
               tmr_next   = SETUP_C;
               state_next = disk_port_pkg::ST_STS_REQ;
            end
         end
         disk_port_pkg::ST_STS_REQ: begin
            if (tmr_reg == 16'h0) begin
               req_next   = 1'b1;
               state_next = disk_port_pkg::ST_STS_ACK;
            end
         end
         disk_port_pkg::ST_STS_ACK: begin
            if (ack_reg && req_reg) begin
               req_next = 1'b0;
            end else if (!ack_reg && !req_reg) begin
               if (msg_reg) begin
                  msg_next   = 1'b0;
                  con_next   = 1'b0;
                  out_next   = 1'b0;
                  oe_next    = 1'b0;
                  bsy_next   = 1'b0;
                  state_next = disk_port_pkg::ST_IDLE;
               end else begin
                  msg_next   = 1'b1;
                  state_next = disk_port_pkg::ST_STS_SET;
               end
            end
         end
         default: state_next = disk_port_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= disk_port_pkg::ST_IDLE;
         for (int i = 0; i < 6; i++) begin
            cmd_reg[i] <= 8'h00;
         end
         idx_reg  <= 3'h0;
         tmr_reg  <= 16'h0000;
         pace_reg <= 16'h0000;
         cnt_reg  <= 11'h000;
         err_reg  <= 8'h00;
         dout_reg <= 8'h00;
         oe_reg   <= 1'b0;
         req_reg  <= 1'b0;
         con_reg  <= 1'b0;
         out_reg  <= 1'b0;
         msg_reg  <= 1'b0;
         bsy_reg  <= 1'b0;
         mv_reg   <= 1'b0;
         mb_reg   <= 8'h00;
         size_reg <= 11'h000;
      end else begin
         state_reg <= state_next;
         for (int i = 0; i < 6; i++) begin
            cmd_reg[i] <= cmd_next[i];
         end
         idx_reg  <= idx_next;
         tmr_reg  <= tmr_next;
         pace_reg <= pace_next;
         cnt_reg  <= cnt_next;
         err_reg  <= err_next;
         dout_reg <= dout_next;
         oe_reg   <= oe_next;
         req_reg  <= req_next;
         con_reg  <= con_next;
         out_reg  <= out_next;
         msg_reg  <= msg_next;
         bsy_reg  <= bsy_next;
         mv_reg   <= mv_next;
         mb_reg   <= mb_next;
         size_reg <= size_next;
      end
   end

   assign data_o             = dout_reg;
   assign data_oe_o          = oe_reg;
   assign byte_request_o     = req_reg;
   assign connection_phase_o = con_reg;
   assign direction_out_o    = out_reg;
   assign message_phase_o    = msg_reg;
   assign controller_busy_o  = bsy_reg;
   assign media_byte_valid_o = mv_reg;
   assign media_byte_o       = mb_reg;
   assign command_opcode_o   = cmd_reg[0];
   assign sector_bytes_o     = size_reg;
endmodule
`default_nettype wire

// ==== tb/disk_host_port_chk.sv ====
// Protocol checker for the disk controller host port.
`timescale 1ns/1ns
`default_nettype none
module disk_host_port_chk (
   input wire logic       clk_i,
   input wire logic       nrst_i,
   input wire logic       byte_acknowledge_i,
   input wire logic [7:0] drive_status_i,
   input wire logic [7:0] data_o,
   input wire logic       data_oe_o,
   input wire logic       byte_request_o,
   input wire logic       connection_phase_o,
   input wire logic       direction_out_o,
   input wire logic       message_phase_o,
   input wire logic       controller_busy_o
);
   logic [7:0] dprev_reg;
   logic [4:0] stab_reg;
   logic [4:0] ack_reg;
   logic [4:0] low_reg;
   // Saturating counters, so long idle stretches never wrap into a false short count.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dprev_reg <= 8'h00;
         stab_reg  <= 5'h00;
         ack_reg   <= 5'h00;
         low_reg   <= 5'h00;
      end else begin
         dprev_reg <= data_o;
         stab_reg  <= (data_o != dprev_reg) ? 5'h00 : stab_reg + 5'(stab_reg != 5'h1F);
         ack_reg   <= !byte_acknowledge_i ? 5'h00 : ack_reg + 5'(ack_reg != 5'h1F);
         low_reg   <= connection_phase_o ? 5'h00 : low_reg + 5'(low_reg != 5'h1F);
      end
   end
   property p_setup;
      @(posedge clk_i) disable iff (!nrst_i) $rose(byte_request_o) && data_oe_o |-> stab_reg >= 5'h06;
   endproperty
   a_setup: assert property (p_setup) else $error("byte not stable before request");
   property p_sample;
      @(posedge clk_i) disable iff (!nrst_i)
         $fell(byte_request_o) && byte_acknowledge_i && !data_oe_o |-> ack_reg >= 5'h09;
   endproperty
   a_sample: assert property (p_sample) else $error("host byte taken too early");
   property p_gap;
      @(posedge clk_i) disable iff (!nrst_i) $rose(connection_phase_o) && direction_out_o |-> low_reg >= 5'h14;
   endproperty
   a_gap: assert property (p_gap) else $error("status entered without phase drop");
   property p_msg;
      @(posedge clk_i) disable iff (!nrst_i) message_phase_o |-> connection_phase_o && direction_out_o;
   endproperty
   a_msg: assert property (p_msg) else $error("message phase outside status");
   property p_drv;
      @(posedge clk_i) disable iff (!nrst_i) $rose(byte_request_o) && message_phase_o |-> data_o == drive_status_i;
   endproperty
   a_drv: assert property (p_drv) else $error("completion byte lacks drive status");
   property p_out;
      @(posedge clk_i) disable iff (!nrst_i) $fell(connection_phase_o) && controller_busy_o |-> $stable(direction_out_o);
   endproperty
   a_out: assert property (p_out) else $error("direction moved with phase drop");
   property p_end;
      @(posedge clk_i) disable iff (!nrst_i)
         $fell(connection_phase_o) && !controller_busy_o |-> !direction_out_o && !message_phase_o && !data_oe_o;
   endproperty
   a_end: assert property (p_end) else $error("status end left signals up");
   property p_rst;
      @(posedge clk_i) disable iff (!nrst_i)
         $rose(nrst_i) |-> !byte_request_o && !connection_phase_o && !controller_busy_o && !message_phase_o;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs up after reset");
endmodule
bind disk_host_port disk_host_port_chk chk (.clk_i(clk_i), .nrst_i(nrst_i), .byte_acknowledge_i(byte_acknowledge_i),
   .drive_status_i(drive_status_i), .data_o(data_o), .data_oe_o(data_oe_o), .byte_request_o(byte_request_o),
   .connection_phase_o(connection_phase_o), .direction_out_o(direction_out_o), .message_phase_o(message_phase_o),
   .controller_busy_o(controller_busy_o));
`default_nettype wire

// ==== tb/disk_host_model.sv ====
// Host adapter model driving select, acknowledge and the data byte.
`timescale 1ns/1ns
`default_nettype none
module disk_host_model (
   input  wire logic       clk_i,
   input  wire logic       byte_request_i,
   input  wire logic       busy_i,
   input  wire logic [7:0] bus_i,
   output logic            select_o,
   output logic            byte_acknowledge_o,
   output logic [7:0]      data_o
);
   // The message phase pin is left unconnected on this adapter.
   initial begin
      select_o           = 1'b0;
      byte_acknowledge_o = 1'b0;
      data_o             = 8'hFF;
   end
   // Selection is confirmed by polling busy, so no edge interrupt needs masking.
   task automatic start(output logic ok);
      ok = 1'b0;
      @(negedge clk_i);
      select_o = 1'b1;
      for (int i = 0; i < 50 && !ok; i++) begin
         @(negedge clk_i);
         ok = busy_i;
      end
      select_o = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] w, input int dly, output logic [7:0] rd, output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 3000 && !ok; i++) begin
         @(negedge clk_i);
         ok = byte_request_i;
      end
      rd = bus_i;
      repeat (dly) @(negedge clk_i);
      if (ok) begin
         byte_acknowledge_o = 1'b1;
         @(negedge clk_i);
         data_o = w;
         ok = 1'b0;
         for (int i = 0; i < 100 && !ok; i++) begin
            @(negedge clk_i);
            ok = !byte_request_i;
         end
         byte_acknowledge_o = 1'b0;
         data_o = ~w;
      end
   endtask
endmodule
`default_nettype wire

// ==== tb/tb_disk_host_port.sv ====
// Self-checking testbench for the disk controller host port.
`timescale 1ns/1ns
`default_nettype none
`include "disk_port_params.svh"
module tb_disk_host_port;
   localparam int SD = 200;
   localparam int DD = 100;
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        sel, ack, oe, req, connection_phase, dout, message_phase, busy, mval, ok, msg_at, req_q;
   logic [7:0]  hdata, bus, mbyte, opc, rd;
   logic [10:0] sbytes;
   int          fail_count = 0;
   int          checks_done = 0;
   int          wr_seen = 0;
   int          cyc = 0;
   int          last = 0;
   int          req_gap = 0;
   always #25 clk_i = ~clk_i;
   disk_host_port #(.FLOP_SD_CYC(SD), .FLOP_DD_CYC(DD), .OVR_SD_CYC(150), .OVR_DD_CYC(75)) dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .select_i(sel), .byte_acknowledge_i(ack), .data_i(hdata),
      .data_o(bus), .data_oe_o(oe), .byte_request_o(req), .connection_phase_o(connection_phase),
      .direction_out_o(dout), .message_phase_o(message_phase), .controller_busy_o(busy),
      .drive_status_i(8'h3C), .media_byte_valid_i(1'b1), .media_byte_i(8'h5A),
      .media_byte_valid_o(mval), .media_byte_o(mbyte), .command_opcode_o(opc), .sector_bytes_o(sbytes));
   disk_host_model host (.clk_i(clk_i), .byte_request_i(req), .busy_i(busy), .bus_i(bus),
      .select_o(sel), .byte_acknowledge_o(ack), .data_o(hdata));
   task automatic summarize();
      if (fail_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic need(input logic good);
      check("handshake", good, 1'b1);
      if (good !== 1'b1) summarize();
   endtask
   always @(posedge clk_i) cyc++;
   // Outputs are looked at on the falling edge, where they have settled.
   always @(negedge clk_i) begin
      if (req === 1'b1 && req_q !== 1'b1) begin
         req_gap = cyc - last;
         last = cyc;
         msg_at = message_phase;
      end
      req_q = req;
   end
   always @(negedge clk_i) if (mval === 1'b1) begin
      check("written byte", mbyte, 8'(wr_seen) ^ 8'hC3);
      wr_seen++;
   end
   task automatic xf(input logic [7:0] w, input int dly);
      host.xfer(w, dly, rd, ok);
      need(ok);
   endtask
   task automatic command(input logic [7:0] op, input logic [7:0] b5);
      host.start(ok);
      need(ok);
      for (int i = 0; i < `CMD_BYTES; i++) xf((i == 0) ? op : (i == 5) ? b5 : 8'h00, 0);
      // The sector size is registered only after the last acknowledge is seen low.
      repeat (6) @(negedge clk_i);
      check("opcode", opc, op);
   endtask
   task automatic status(input logic [7:0] err);
      int n = 0;
      while (!(connection_phase === 1'b1 && dout === 1'b1) && n < 3000) begin
         @(negedge clk_i);
         n++;
      end
      xf(8'h00, 0);
      check("error byte", rd, err);
      check("first byte message", msg_at, 1'b0);
      xf(8'h00, 0);
      check("second byte message", msg_at, 1'b1);
      check("drive status", rd, 8'h3C);
      n = 0;
      while (busy !== 1'b0 && n < 50) begin
         @(negedge clk_i);
         n++;
      end
      check("idle", {busy, connection_phase, dout, message_phase, oe, req}, 6'h00);
      if (n == 50) summarize();
   endtask
   task automatic t_reset();
      command(`OPC_READ, 8'h02);
      @(negedge clk_i);
      nrst_i = 1'b0;
      repeat (2) @(negedge clk_i);
      check("reset outputs", {req, connection_phase, dout, message_phase, busy}, 5'h00);
      nrst_i = 1'b1;
      repeat (5) @(negedge clk_i);
   endtask
   task automatic t_fixed_read();
      command(`OPC_READ, 8'h02);
      check("fixed size", sbytes, 11'd256);
      for (int i = 0; i < 256; i++) begin
         xf(8'h00, 0);
         check("read byte", rd, 8'h5A);
      end
      check("fixed spacing", req_gap, `FIX_PERIOD_CYC);
      status(`ERR_OK);
   endtask
   task automatic t_sd_write();
      command(`OPC_WRITE, 8'h00);
      check("single size", sbytes, 11'd128);
      wr_seen = 0;
      for (int i = 0; i < 128; i++) xf(8'(i) ^ 8'hC3, 0);
      check("single spacing", req_gap, SD);
      status(`ERR_OK);
      check("written count", wr_seen, 128);
   endtask
   task automatic t_dd_overrun();
      command(`OPC_READ, 8'h05);
      check("double size", sbytes, 11'd256);
      for (int i = 0; i < 3; i++) xf(8'h00, 0);
      check("double spacing", req_gap, DD);
      status(`ERR_OVERRUN);
   endtask
   task automatic t_fast();
      command(`OPC_READ, 8'h15);
      for (int i = 0; i < 256; i++) xf(8'h00, (i == 0) ? 120 : 0);
      status(`ERR_OK);
   endtask
   task automatic t_other();
      command(`OPC_READ, 8'h01);
      status(`ERR_BAD_SIZE);
      command(8'h01, 8'h06);
      check("fixed large size", sbytes, 11'd512);
      status(`ERR_OK);
   endtask
   initial begin
      repeat (10) @(negedge clk_i);
      nrst_i = 1'b1;
      repeat (5) @(negedge clk_i);
      t_reset();
      t_fixed_read();
      t_sd_write();
      t_dd_overrun();
      t_fast();
      t_other();
      summarize();
   end
endmodule
`default_nettype wire
